/* File: tccio_top.sv */
// five-channel timer clock select, counter clear and capture/compare pin control
// assumes an axi4-lite master on aclk and asynchronous external clock and pin inputs
// Functional notes
// - bit 7 of clock control and pin control registers reads 1, ignores writes.
// - clock control register becomes 0x80 on reset and in standby.
// - clear select 00 never clears, 01 on register A event, 10 on register B.
// - clear select 11 clears along with other timers chosen in sync select.
// - clearing event is compare match in compare mode, capture in capture mode.
// - edge select 00 rising, 01 falling, 1x both edges of external clock.
// - prescale 000 system clock, 001 divide 2, 010 divide 4, 011 divide 8.
// - prescale 100 to 111 choose external clock inputs a, b, c, d.
// - internal clock counts its falling edges; external counts the selected edges.
// - channel 2 in phase counting ignores edge and prescale settings.
// - five channels, each with its own identical control registers.
// - pin control register becomes 0x88 on reset and in standby.
// - pin control of channels 3 and 4 is inert in the pwm modes.
// - register b function 0xx is compare: none, drive 0, drive 1, toggle.
// - channel 2 toggle setting drives 1 instead.
// - register b function 1xx is capture: rising, falling, both edges.
// - pins become outputs in compare mode and inputs in capture mode.
// - compare output is 0 after reset until the first match.
// - compare continuously against the counter, flag match on equality.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tccio_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic standby,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clock_in_a,
	input wire logic ext_clock_in_b,
	input wire logic ext_clock_in_c,
	input wire logic ext_clock_in_d,
	input wire logic [4:0] capcomp_pin_a_in,
	output logic [4:0] capcomp_pin_a_out,
	output logic [4:0] capcomp_pin_a_oe,
	input wire logic [4:0] capcomp_pin_b_in,
	output logic [4:0] capcomp_pin_b_out,
	output logic [4:0] capcomp_pin_b_oe
);
	localparam int NCH = tccio_pkg::NCH;

	// standby reinitialises the timer registers, counters and pin outputs, but not the bus, edge detector or prescaler state
	logic init;
	assign init = !aresetn || standby;

	tccio_edge_if #(.W(tccio_pkg::NEXT)) ext_ev();
	tccio_edge_if #(.W(2 * NCH)) pin_ev();
	tccio_tick_if tk();

	tccio_edge #(.W(tccio_pkg::NEXT)) u_ext_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.pin_in({ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a}),
		.ev(ext_ev.src)
	);

	tccio_edge #(.W(2 * NCH)) u_pin_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.pin_in({capcomp_pin_b_in, capcomp_pin_a_in}),
		.ev(pin_ev.src)
	);

	tccio_presc u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tk(tk.src)
	);

	// 00 rising, 01 falling, 1x both; the same coding serves clock and capture edges
	function automatic logic pick_edge(input logic [1:0] sel, input logic r, input logic f);
		pick_edge = sel[1] ? (r | f) : (sel[0] ? f : r);
	endfunction

	function automatic logic next_out(input logic [1:0] act, input logic cur, input logic notog);
		case (act)
			tccio_pkg::TCCIO_OUT_ZERO: next_out = 1'b0;
			tccio_pkg::TCCIO_OUT_ONE: next_out = 1'b1;
			tccio_pkg::TCCIO_OUT_TOGGLE: next_out = notog ? 1'b1 : ~cur;
			default: next_out = cur;
		endcase
	endfunction

	// write channel: address and data latched independently, answered when both are in
	logic aw_have_q;
	logic w_have_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	logic wr_fire;
	logic [2:0] wr_ch;
	logic [4:0] wr_reg;
	logic wr_ch_hit;
	logic wr_sync;
	logic wr_mode;
	logic wr_hit;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q && ce;
	assign wr_ch = awaddr_q[tccio_pkg::CH_MSB:tccio_pkg::CH_LSB];
	assign wr_reg = awaddr_q[tccio_pkg::CH_LSB-1:0];
	assign wr_ch_hit = (awaddr_q[11:8] == tccio_pkg::CH_AREA) && (wr_ch < NCH) &&
		(wr_reg == tccio_pkg::REG_CCC || wr_reg == tccio_pkg::REG_IOC ||
		wr_reg == tccio_pkg::REG_CNT || wr_reg == tccio_pkg::REG_GRA ||
		wr_reg == tccio_pkg::REG_GRB);
	assign wr_sync = awaddr_q == tccio_pkg::OFF_SYNC;
	assign wr_mode = awaddr_q == tccio_pkg::OFF_MODE;
	assign wr_hit = wr_ch_hit || wr_sync || wr_mode;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= tccio_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? tccio_pkg::RESP_OKAY : tccio_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// global registers: sync select per channel, phase counting and pwm mode bits
	logic [4:0] sync_q;
	logic [1:0] mode_q;
	always_ff @(posedge aclk) begin
		if (init) begin
			sync_q <= tccio_pkg::SYNC_RST;
			mode_q <= tccio_pkg::MODE_RST;
		end else if (ce && wr_fire && wstrb_q[0]) begin
			if (wr_sync) begin
				sync_q <= wdata_q[4:0];
			end
			if (wr_mode) begin
				mode_q <= wdata_q[1:0];
			end
		end
	end

	logic [7:0] ccc_q [NCH];
	logic [7:0] ioc_q [NCH];
	logic [15:0] cnt_q [NCH];
	logic [15:0] gra_q [NCH];
	logic [15:0] grb_q [NCH];
	logic [31:0] rd_word [NCH];
	logic [NCH-1:0] own_clr;
	logic [NCH-1:0] outa_q;
	logic [NCH-1:0] outb_q;
	logic [NCH-1:0] oea;
	logic [NCH-1:0] oeb;

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			logic sel;
			logic [1:0] clr;
			logic [1:0] es;
			logic [2:0] psc;
			logic [2:0] ioa;
			logic [2:0] iob;
			logic phase;
			logic pwm_off;
			logic ext_tick;
			logic int_tick;
			logic cnt_tick;
			logic cap_mode_a;
			logic cap_mode_b;
			logic cap_a;
			logic cap_b;
			logic match_a;
			logic match_b;
			logic ma_prev_q;
			logic mb_prev_q;
			logic ev_a;
			logic ev_b;
			logic sync_clr;
			logic do_clr;

			assign sel = wr_fire && wr_ch_hit && (wr_ch == i);
			assign clr = ccc_q[i][tccio_pkg::CLR_HI:tccio_pkg::CLR_LO];
			assign es = ccc_q[i][tccio_pkg::EDGE_HI:tccio_pkg::EDGE_LO];
			assign psc = ccc_q[i][tccio_pkg::PSC_HI:tccio_pkg::PSC_LO];
			assign ioa = ioc_q[i][tccio_pkg::IOA_HI:tccio_pkg::IOA_LO];
			assign iob = ioc_q[i][tccio_pkg::IOB_HI:tccio_pkg::IOB_LO];
			assign phase = (i == tccio_pkg::PHASE_CH) && mode_q[tccio_pkg::MODE_PHASE_BIT];
			assign pwm_off = (i == tccio_pkg::PWM_CH_LO || i == tccio_pkg::PWM_CH_HI) &&
				mode_q[tccio_pkg::MODE_PWM34_BIT];

			// counter clock source
			assign ext_tick = pick_edge(es, ext_ev.rise[psc[1:0]], ext_ev.fall[psc[1:0]]);
			assign int_tick = tk.tick[psc[1:0]];
			// phase counting turns this path off, and no other count source drives the counter
			assign cnt_tick = !phase && (psc[2] ? ext_tick : int_tick);

			// pin functions; pwm modes of channels 3 and 4 leave the pin control inert
			assign cap_mode_a = ioa[2] && !pwm_off;
			assign cap_mode_b = iob[2] && !pwm_off;
			assign cap_a = cap_mode_a && pick_edge(ioa[1:0], pin_ev.rise[i], pin_ev.fall[i]);
			assign cap_b = cap_mode_b &&
				pick_edge(iob[1:0], pin_ev.rise[NCH+i], pin_ev.fall[NCH+i]);
			// only the first cycle of equality counts, so a stalled counter fires once
			assign match_a = !cap_mode_a && (cnt_q[i] == gra_q[i]) && !ma_prev_q;
			assign match_b = !cap_mode_b && (cnt_q[i] == grb_q[i]) && !mb_prev_q;
			assign ev_a = cap_mode_a ? cap_a : match_a;
			assign ev_b = cap_mode_b ? cap_b : match_b;

			assign own_clr[i] = (clr == tccio_pkg::TCCIO_CLR_GRA && ev_a) ||
				(clr == tccio_pkg::TCCIO_CLR_GRB && ev_b);
			assign sync_clr = (clr == tccio_pkg::TCCIO_CLR_SYNC) && sync_q[i] &&
				|(own_clr & sync_q);
			assign do_clr = own_clr[i] || sync_clr;

			always_ff @(posedge aclk) begin
				if (init) begin
					ccc_q[i] <= tccio_pkg::CCC_RST;
					ioc_q[i] <= tccio_pkg::IOC_RST;
				end else if (ce && sel && wstrb_q[0]) begin
					if (wr_reg == tccio_pkg::REG_CCC) begin
						ccc_q[i] <= wdata_q[7:0] | tccio_pkg::CCC_ONES;
					end
					if (wr_reg == tccio_pkg::REG_IOC) begin
						ioc_q[i] <= wdata_q[7:0] | tccio_pkg::IOC_ONES;
					end
				end
			end

			// clear beats a software write, which beats a count step
			always_ff @(posedge aclk) begin
				if (init) begin
					cnt_q[i] <= tccio_pkg::CNT_RST;
				end else if (ce) begin
					if (do_clr) begin
						cnt_q[i] <= tccio_pkg::CNT_RST;
					end else if (sel && wr_reg == tccio_pkg::REG_CNT) begin
						if (wstrb_q[0]) begin
							cnt_q[i][7:0] <= wdata_q[7:0];
						end
						if (wstrb_q[1]) begin
							cnt_q[i][15:8] <= wdata_q[15:8];
						end
					end else if (cnt_tick) begin
						cnt_q[i] <= cnt_q[i] + 16'h0001;
					end
				end
			end

			// a capture wins over a software write in the same cycle
			always_ff @(posedge aclk) begin
				if (init) begin
					gra_q[i] <= tccio_pkg::GR_RST;
					grb_q[i] <= tccio_pkg::GR_RST;
				end else if (ce) begin
					if (cap_a) begin
						gra_q[i] <= cnt_q[i];
					end else if (sel && wr_reg == tccio_pkg::REG_GRA) begin
						if (wstrb_q[0]) begin
							gra_q[i][7:0] <= wdata_q[7:0];
						end
						if (wstrb_q[1]) begin
							gra_q[i][15:8] <= wdata_q[15:8];
						end
					end
					if (cap_b) begin
						grb_q[i] <= cnt_q[i];
					end else if (sel && wr_reg == tccio_pkg::REG_GRB) begin
						if (wstrb_q[0]) begin
							grb_q[i][7:0] <= wdata_q[7:0];
						end
						if (wstrb_q[1]) begin
							grb_q[i][15:8] <= wdata_q[15:8];
						end
					end
				end
			end

			always_ff @(posedge aclk) begin
				if (init) begin
					ma_prev_q <= 1'b0;
					mb_prev_q <= 1'b0;
					outa_q[i] <= 1'b0;
					outb_q[i] <= 1'b0;
				end else if (ce) begin
					ma_prev_q <= cnt_q[i] == gra_q[i];
					mb_prev_q <= cnt_q[i] == grb_q[i];
					if (match_a && !pwm_off) begin
						outa_q[i] <= next_out(ioa[1:0], outa_q[i], i == tccio_pkg::NOTOG_CH);
					end
					if (match_b && !pwm_off) begin
						outb_q[i] <= next_out(iob[1:0], outb_q[i],
							i == tccio_pkg::NOTOG_CH);
					end
				end
			end

			assign oea[i] = !ioa[2] && !pwm_off;
			assign oeb[i] = !iob[2] && !pwm_off;

			assign rd_word[i] =
				(s_axi_araddr[4:0] == tccio_pkg::REG_CCC) ? {24'h000000, ccc_q[i]} :
				(s_axi_araddr[4:0] == tccio_pkg::REG_IOC) ? {24'h000000, ioc_q[i]} :
				(s_axi_araddr[4:0] == tccio_pkg::REG_CNT) ? {16'h0000, cnt_q[i]} :
				(s_axi_araddr[4:0] == tccio_pkg::REG_GRA) ? {16'h0000, gra_q[i]} :
				{16'h0000, grb_q[i]};
		end
	endgenerate

	assign capcomp_pin_a_out = outa_q;
	assign capcomp_pin_b_out = outb_q;
	assign capcomp_pin_a_oe = oea;
	assign capcomp_pin_b_oe = oeb;

	// read channel: one read in flight, data registered at acceptance
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [2:0] rd_ch;
	logic [4:0] rd_reg;
	logic rd_ch_hit;
	logic rd_sync;
	logic rd_mode;
	logic [31:0] rd_mux;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign rd_ch = s_axi_araddr[tccio_pkg::CH_MSB:tccio_pkg::CH_LSB];
	assign rd_reg = s_axi_araddr[tccio_pkg::CH_LSB-1:0];
	assign rd_ch_hit = (s_axi_araddr[11:8] == tccio_pkg::CH_AREA) && (rd_ch < NCH) &&
		(rd_reg == tccio_pkg::REG_CCC || rd_reg == tccio_pkg::REG_IOC ||
		rd_reg == tccio_pkg::REG_CNT || rd_reg == tccio_pkg::REG_GRA ||
		rd_reg == tccio_pkg::REG_GRB);
	assign rd_sync = s_axi_araddr == tccio_pkg::OFF_SYNC;
	assign rd_mode = s_axi_araddr == tccio_pkg::OFF_MODE;
	assign rd_mux = rd_ch_hit ? rd_word[rd_ch] :
		rd_sync ? {27'h0, sync_q} :
		rd_mode ? {30'h0, mode_q} : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= tccio_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= (rd_ch_hit || rd_sync || rd_mode) ?
					tccio_pkg::RESP_OKAY : tccio_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule

/* File: tccio_pkg.sv */
// constants, field positions and encodings for the timer clock, clear and pin control block
// assumes a 12-bit byte address space behind an axi4-lite slave with 32-bit data
package tccio_pkg;

	localparam int NCH = 5;
	localparam int NEXT = 4;
	localparam int ADDR_W = 12;
	localparam int DIV_W = 3;
	localparam int PHASE_CH = 2;
	localparam int PWM_CH_LO = 3;
	localparam int PWM_CH_HI = 4;
	localparam int NOTOG_CH = 2;

	// per channel window: channel index in addr[7:5], register in addr[4:0]
	localparam int CH_LSB = 5;
	localparam int CH_MSB = 7;
	localparam logic [3:0] CH_AREA = 4'h0;
	localparam logic [4:0] REG_CCC = 5'h00;
	localparam logic [4:0] REG_IOC = 5'h04;
	localparam logic [4:0] REG_CNT = 5'h08;
	localparam logic [4:0] REG_GRA = 5'h0C;
	localparam logic [4:0] REG_GRB = 5'h10;
	localparam logic [11:0] OFF_SYNC = 12'h100;
	localparam logic [11:0] OFF_MODE = 12'h104;

	localparam logic [7:0] CCC_RST = 8'h80;
	localparam logic [7:0] CCC_ONES = 8'h80;
	localparam logic [7:0] IOC_RST = 8'h88;
	localparam logic [7:0] IOC_ONES = 8'h88;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] GR_RST = 16'hFFFF;
	localparam logic [4:0] SYNC_RST = 5'h00;
	localparam logic [1:0] MODE_RST = 2'h0;

	localparam int CLR_HI = 6;
	localparam int CLR_LO = 5;
	localparam int EDGE_HI = 4;
	localparam int EDGE_LO = 3;
	localparam int PSC_HI = 2;
	localparam int PSC_LO = 0;
	localparam int IOB_HI = 6;
	localparam int IOB_LO = 4;
	localparam int IOA_HI = 2;
	localparam int IOA_LO = 0;
	localparam int MODE_PHASE_BIT = 0;
	localparam int MODE_PWM34_BIT = 1;

	typedef enum logic [1:0] {
		TCCIO_CLR_NONE = 2'b00,
		TCCIO_CLR_GRA = 2'b01,
		TCCIO_CLR_GRB = 2'b10,
		TCCIO_CLR_SYNC = 2'b11
	} tccio_clr_t;

	typedef enum logic [1:0] {
		TCCIO_OUT_NONE = 2'b00,
		TCCIO_OUT_ZERO = 2'b01,
		TCCIO_OUT_ONE = 2'b10,
		TCCIO_OUT_TOGGLE = 2'b11
	} tccio_out_t;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: tccio_if.sv */
// carriers between the edge detectors, the prescaler and the channel logic
// assumes all parties run on aclk
`timescale 1ns/1ps
interface tccio_edge_if #(parameter int W = 1);
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src(output rise, output fall);
	modport dst(input rise, input fall);
endinterface

interface tccio_tick_if;
	logic [3:0] tick;
	modport src(output tick);
	modport dst(input tick);
endinterface

/* File: tccio_edge.sv */
// two-stage synchroniser and edge detector for asynchronous pins
// assumes pin inputs may change at any time relative to aclk
`timescale 1ns/1ps
module tccio_edge #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [W-1:0] pin_in,
	tccio_edge_if.src ev
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	logic [W-1:0] rise_q;
	logic [W-1:0] fall_q;

	// one-cycle pulse per detected edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
			rise_q <= '0;
			fall_q <= '0;
		end else if (ce) begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			rise_q <= sync_q & ~prev_q;
			fall_q <= ~sync_q & prev_q;
		end
	end

	assign ev.rise = rise_q;
	assign ev.fall = fall_q;
endmodule

/* File: tccio_presc.sv */
// internal clock prescaler: strobes at the falling edge of the divided clocks
// assumes the counter logic samples the strobes in the same aclk cycle
`timescale 1ns/1ps
module tccio_presc (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	tccio_tick_if.src tk
);
	logic [tccio_pkg::DIV_W-1:0] div_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '0;
		end else if (ce) begin
			div_q <= div_q + 3'h1;
		end
	end

	// each divided clock falls when its counter bit wraps to zero
	assign tk.tick[0] = 1'b1;
	assign tk.tick[1] = div_q[0];
	assign tk.tick[2] = &div_q[1:0];
	assign tk.tick[3] = &div_q;
endmodule

/* File: tccio_top_chk.sv */
// concurrent checks on the ports of the timer clock, clear and pin control block
// assumes a single aclk domain with synchronous active-low reset
`timescale 1ns/1ps
module tccio_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] capcomp_pin_a_out,
	input wire logic [4:0] capcomp_pin_a_oe,
	input wire logic [4:0] capcomp_pin_b_out,
	input wire logic [4:0] capcomp_pin_b_oe
);
	logic [11:0] ar_q;
	logic [11:0] ar_d;
	// remember the read address so the answer can be judged a cycle later
	assign ar_d = (s_axi_arvalid && s_axi_arready && ce) ? s_axi_araddr : ar_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_q <= 12'h000;
		end else begin
			ar_q <= ar_d;
		end
	end
	wire rd_ccc = s_axi_rvalid && ar_q < 12'h0A0 && ar_q[4:0] == tccio_pkg::REG_CCC;
	wire rd_ioc = s_axi_rvalid && ar_q < 12'h0A0 && ar_q[4:0] == tccio_pkg::REG_IOC;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready && ce;
	endsequence
	sequence w_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
	endsequence
	pin_rst_a: assert property ($rose(aresetn) |-> (capcomp_pin_a_out | capcomp_pin_b_out) == 5'h00)
		else $error("compare output not low after reset");
	oe_rst_a: assert property ($rose(aresetn) |-> (capcomp_pin_a_oe & capcomp_pin_b_oe) == 5'h1F)
		else $error("pins not outputs after reset");
	ccc_bit_a: assert property (rd_ccc |-> s_axi_rdata[31:7] == 25'h1)
		else $error("clock control reserved bit wrong");
	ioc_bits_a: assert property (rd_ioc |-> s_axi_rdata[7] && s_axi_rdata[3])
		else $error("pin control reserved bits wrong");
	unmap_rd_a: assert property (s_axi_rvalid && ar_q >= 12'h108 |-> s_axi_rresp == tccio_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	rd_lat_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	wr_lat_a: assert property (w_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer timing wrong");
	b_blk_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	r_blk_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
endmodule
bind tccio_top tccio_top_chk i_chk (.aclk, .aresetn, .ce, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .capcomp_pin_a_out,
	.capcomp_pin_a_oe, .capcomp_pin_b_out, .capcomp_pin_b_oe);

/* File: tccio_pins.sv */
// model of the external clock pins and the capture/compare pins
// assumes the bench calls its tasks from a thread synchronous to aclk
`timescale 1ns/1ps
module tccio_pins (
	input wire logic aclk,
	input wire logic [4:0] oe_a,
	input wire logic [4:0] oe_b,
	input wire logic [4:0] out_a,
	input wire logic [4:0] out_b,
	output logic [3:0] ext,
	output logic [4:0] pin_a,
	output logic [4:0] pin_b
);
	logic [4:0] drv_a;
	logic [4:0] drv_b;
	// the wire level follows whichever side drives it
	assign pin_a = (oe_a & out_a) | (~oe_a & drv_a);
	assign pin_b = (oe_b & out_b) | (~oe_b & drv_b);
	initial begin
		ext = 4'h0;
		drv_a = 5'h00;
		drv_b = 5'h00;
	end
	// clocks rest low between bursts; four cycles a phase outlasts the synchroniser
	task automatic burst(input int k, input int n);
		repeat (n) begin
			repeat (4) @(posedge aclk);
			ext[k] <= 1'b1;
			repeat (4) @(posedge aclk);
			ext[k] <= 1'b0;
		end
	endtask
	task automatic set_b(input int c, input logic v);
		@(posedge aclk);
		drv_b[c] <= v;
	endtask
endmodule

/* File: tccio_top_bench.sv */
// self-checking bench for the timer clock, clear and pin control block
// assumes the checker is bound in and the pin model stands at the far side
`timescale 1ns/1ps
module tccio_top_bench;
	localparam logic [4:0] CC = tccio_pkg::REG_CCC;
	localparam logic [4:0] IO = tccio_pkg::REG_IOC;
	localparam logic [4:0] CN = tccio_pkg::REG_CNT;
	localparam logic [4:0] GA = tccio_pkg::REG_GRA;
	localparam logic [4:0] GB = tccio_pkg::REG_GRB;
	logic aclk, aresetn, ce, standby;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, ext;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [4:0] capcomp_pin_a_in, capcomp_pin_a_out, capcomp_pin_a_oe;
	logic [4:0] capcomp_pin_b_in, capcomp_pin_b_out, capcomp_pin_b_oe;
	int num_errors, total_checks;
	tccio_top i_dut (.aclk, .aresetn, .ce, .standby, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_in_a(ext[0]),
		.ext_clock_in_b(ext[1]), .ext_clock_in_c(ext[2]), .ext_clock_in_d(ext[3]),
		.capcomp_pin_a_in, .capcomp_pin_a_out, .capcomp_pin_a_oe, .capcomp_pin_b_in,
		.capcomp_pin_b_out, .capcomp_pin_b_oe);
	tccio_pins i_pins (.aclk, .oe_a(capcomp_pin_a_oe), .oe_b(capcomp_pin_b_oe),
		.out_a(capcomp_pin_a_out), .out_b(capcomp_pin_b_out), .ext, .pin_a(capcomp_pin_a_in),
		.pin_b(capcomp_pin_b_in));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic close_out();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ckr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		total_checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h to %h", $time, g, lo, hi);
		end
	endtask
	function automatic logic [11:0] ad(input int n, input logic [4:0] o);
		return 12'(n * 32) | {7'h00, o};
	endfunction
	// address and data rise together; each drops on its own ready
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid) break;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (n == 40) ck(32'h1, 32'h0);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n == 40) ck(32'h1, 32'h0);
	endtask
	task automatic t_reset();
		ck(32'(capcomp_pin_a_out | capcomp_pin_b_out), 32'h0);
		for (int n = 0; n < tccio_pkg::NCH; n++) begin
			rd(ad(n, CC));
			ck(d, 32'h80);
			rd(ad(n, IO));
			ck(d, 32'h88);
			wr(ad(n, CC), 32'h0);
			wr(ad(n, IO), 32'h0);
			rd(ad(n, CC));
			ck(d, 32'h80);
			rd(ad(n, IO));
			ck(d, 32'h88);
		end
		rd(12'h200);
		ck(32'(r), 32'(tccio_pkg::RESP_SLVERR));
		ck(d, 32'h0);
		wr(12'h200, 32'h0);
		ck(32'(r), 32'(tccio_pkg::RESP_SLVERR));
	endtask
	task automatic t_presc();
		for (int k = 0; k < 4; k++) begin
			wr(ad(0, CC), 32'(k));
			wr(ad(0, CN), 32'h0);
			repeat (64) @(posedge aclk);
			ce <= 1'b0;
			repeat (20) @(posedge aclk);
			ce <= 1'b1;
			rd(ad(0, CN));
			ckr(d, 32'(64 >> k), 32'((72 >> k) + 1));
		end
	endtask
	// only the selected pin toggles, so a wrong source mapping counts nothing
	task automatic t_ext();
		for (int p = 0; p < 4; p++) begin
			for (int e = 0; e < 4; e++) begin
				wr(ad(1, CC), 32'(4 + p + e * 8));
				wr(ad(1, CN), 32'h0);
				i_pins.burst(p, 3);
				repeat (8) @(posedge aclk);
				rd(ad(1, CN));
				ck(d, (e > 1) ? 32'h6 : 32'h3);
			end
		end
		wr(tccio_pkg::OFF_MODE, 32'h1);
		wr(ad(2, CC), 32'h0);
		wr(ad(2, CN), 32'h0);
		repeat (20) @(posedge aclk);
		rd(ad(2, CN));
		ck(d, 32'h0);
		wr(tccio_pkg::OFF_MODE, 32'h0);
	endtask
	task automatic t_cmp();
		logic [7:0] codes [5] = '{8'h20, 8'h10, 8'h20, 8'h30, 8'h00};
		logic [4:0] ex0 = 5'b00101;
		logic [4:0] ex2 = 5'b11101;
		wr(ad(0, CC), 32'h0);
		for (int i = 0; i < 5; i++) begin
			for (int c = 0; c < 3; c += 2) begin
				wr(ad(c, IO), 32'(codes[i]));
				wr(ad(c, GB), 32'h8);
				wr(ad(c, CN), 32'h0);
				repeat (20) @(posedge aclk);
				ck(32'(capcomp_pin_b_out[c]), 32'((c == 2) ? ex2[i] : ex0[i]));
			end
		end
	endtask
	task automatic t_clr();
		logic [7:0] lo [3] = '{8'd30, 8'd0, 8'd0};
		logic [7:0] hi [3] = '{8'd60, 8'd9, 8'd5};
		wr(ad(3, GA), 32'h9);
		wr(ad(3, GB), 32'h5);
		for (int k = 0; k < 3; k++) begin
			wr(ad(3, CC), 32'(k * 32));
			wr(ad(3, CN), 32'h0);
			repeat (40) @(posedge aclk);
			rd(ad(3, CN));
			ckr(d, 32'(lo[k]), 32'(hi[k]));
		end
	endtask
	task automatic step(input logic v, input logic ex);
		wr(ad(4, GB), 32'h1234);
		i_pins.set_b(4, v);
		repeat (10) @(posedge aclk);
		rd(ad(4, GB));
		ck(32'(d[15:0] !== 16'h1234), 32'(ex));
	endtask
	task automatic t_cap();
		logic [3:0] exr = 4'b1101;
		logic [3:0] exf = 4'b1110;
		wr(ad(4, CC), 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(ad(4, IO), 32'(64 + k * 16));
			wr(ad(4, CN), 32'h0);
			ck(32'(capcomp_pin_b_oe[4]), 32'h0);
			step(1'b1, exr[k]);
			step(1'b0, exf[k]);
		end
		wr(ad(4, IO), 32'h40);
		wr(ad(4, CC), 32'h40);
		step(1'b1, 1'b1);
		rd(ad(4, CN));
		ckr(d, 32'h0, 32'h10);
	endtask
	task automatic t_sync();
		wr(ad(1, CC), 32'h60);
		for (int k = 0; k < 2; k++) begin
			wr(tccio_pkg::OFF_SYNC, k ? 32'h2 : 32'hA);
			wr(ad(1, CN), 32'h0);
			repeat (40) @(posedge aclk);
			rd(ad(1, CN));
			ckr(d, k ? 32'd30 : 32'd0, k ? 32'd60 : 32'd9);
		end
	endtask
	task automatic t_pwm();
		wr(tccio_pkg::OFF_MODE, 32'h2);
		ck(32'({capcomp_pin_a_oe[4:3], capcomp_pin_b_oe[3]}), 32'h0);
		ck(32'(capcomp_pin_a_oe[2:0]), 32'h7);
		wr(tccio_pkg::OFF_MODE, 32'h0);
		ck(32'(capcomp_pin_a_oe[4:3]), 32'h3);
	endtask
	task automatic t_stby();
		wr(ad(4, CC), 32'h7F);
		wr(ad(4, IO), 32'h77);
		standby <= 1'b1;
		repeat (2) @(posedge aclk);
		standby <= 1'b0;
		rd(ad(4, CC));
		ck(d, 32'h80);
		rd(ad(4, IO));
		ck(d, 32'h88);
	endtask
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		standby = 1'b0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_presc();
		t_ext();
		t_cmp();
		t_clr();
		t_cap();
		t_sync();
		t_pwm();
		t_stby();
		close_out();
	end
	// a few thousand cycles needed; wide margin
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule
